// File: verilog/aar_pkg.sv
/*
 * Package for the auto-negotiation ability register slice: register
 * indices, field masks, reset values and the request carrier.
 * Assumes a 16-bit management register space indexed by a 5-bit address.
 */
package aar_pkg;

   localparam int          DW          = 16;     // Register width
   localparam int          AW          = 5;      // Register address width

   // Register indices on the management port
   localparam logic [4:0]  IDX_ID_HIGH = 5'h03;  // Upper identifier
   localparam logic [4:0]  IDX_ADV     = 5'h04;  // Advertisement
   localparam logic [4:0]  IDX_PARTNER = 5'h05;  // Partner ability

   // Identifier field positions
   localparam int          ID_OUI_LSB  = 10;     // Vendor id bits 19..24
   localparam int          ID_MOD_LSB  = 4;      // Model number
   localparam int          ID_REV_LSB  = 0;      // Revision number

   // Advertisement layout
   localparam logic [15:0] ADV_WMASK   = 16'hA1E0; // Bits 15, 13, 8..5 writable
   localparam logic [15:0] ADV_FIXED   = 16'h0001; // Selector 00001, rest zero
   localparam logic [15:0] ADV_RESET   = 16'h01E1; // Abilities on, selector set
   localparam int          ADV_NP      = 15;     // Next-page offer
   localparam int          ADV_RF      = 13;     // Local fault
   localparam int          ABIL_LSB    = 5;      // Lowest ability flag
   localparam int          ABIL_N      = 4;      // Number of ability flags
   localparam int          T4_BIT      = 9;      // Unsupported T4 ability

   // Partner layout: T4 and reserved bits never captured
   localparam logic [15:0] LP_MASK     = 16'hE1FF; // Bits 15..13, 8..0
   localparam logic [15:0] LP_RESET    = 16'h0000; // Nothing heard yet
   localparam logic [15:0] ZERO_WORD   = 16'h0000; // Unmapped read value

   // Management request carrier
   typedef struct packed {
      logic          rd;      // Read strobe
      logic          wr;      // Write strobe
      logic [4:0]    addr;    // Register index
      logic [15:0]   wdata;   // Write data
   } aar_req_t;

endpackage

// File: verilog/aar_partner_capture.sv
/*
 * Partner ability capture: holds the last received partner word, keeping
 * only the bits the partner register reports.
 * Assumes the negotiation engine pulses the valid strobe once per word.
 */
`timescale 1ns/1ns
module aar_partner_capture #(
   parameter int                DW   = 16,              // Word width
   parameter logic [DW-1:0]     MASK = 16'hE1FF,        // Bits kept
   parameter logic [DW-1:0]     RSTV = 16'h0000         // Reset value
) (
   input  wire logic            clk,                    // Core clock
   input  wire logic            reset_n,                // Async reset, low
   input  wire logic            clear,                  // Forget partner word
   input  wire logic            valid,                  // New word strobe
   input  wire logic [DW-1:0]   word,                   // Received word
   output logic      [DW-1:0]   held                    // Captured bits
);

   // One flop per kept bit; masked-out bits are tied low whatever the reset value
   genvar i;
   generate
      for (i = 0; i < DW; i++) begin : g_bit
         if (MASK[i]) begin : g_kept
            always_ff @(posedge clk or negedge reset_n) begin
               if (!reset_n) begin
                  held[i] <= RSTV[i];
               end else if (valid) begin
                  held[i] <= word[i];
               end else if (clear) begin
                  held[i] <= RSTV[i];
               end
            end
         end else begin : g_zero
            assign held[i] = 1'b0;
         end
      end
   endgenerate

endmodule

// File: verilog/aar_regs.sv
/*
 * Auto-negotiation ability register slice: upper identifier,
 * advertisement and partner ability registers behind a simple
 * management register port.
 * Assumes the management frame logic issues one-cycle read and write
 * strobes, and the negotiation engine supplies received partner words.
 */
// Functional notes
// - Identifier register returns fixed vendor, model, revision
// - Advertised next-page flag writable, resets to zero
// - Advertised local fault writable, resets to zero
// - Four ability flags writable, each reset to one
// - T4 ability reads zero in both registers
// - Advertised selector fixed at 00001
// - Partner abilities read-only, zero until received
// - Partner selector received; reserved bits read zero
`timescale 1ns/1ns
module aar_regs #(
   parameter logic [5:0]     OUI_HI   = 6'h2A,          // Arbitrary vendor bits
   parameter logic [5:0]     MODEL    = 6'h11,          // Arbitrary model number
   parameter logic [3:0]     REVISION = 4'h3            // Arbitrary revision
) (
   input  wire logic              CLK,                  // Core clock, 125 MHz
   input  wire logic              RESET_N,              // Async reset, low
   input  wire aar_pkg::aar_req_t REG_REQ,              // Management request
   output logic      [15:0]       REG_RDATA,            // Read data
   output logic                   REG_RVALID,           // Read data valid
   input  wire logic              LP_VALID,             // Partner word strobe
   input  wire logic [15:0]       LP_WORD,              // Received partner word
   input  wire logic              LP_CLEAR,             // Restart: drop partner
   output logic      [15:0]       ADV_WORD              // Word to transmit
);

   logic [15:0] adv;          // Advertisement storage, fixed bits included
   logic [15:0] partner;      // Captured partner bits
   logic [15:0] id_word;      // Constant identifier word
   logic [15:0] next_rdata;   // Read mux result
   logic        adv_wr;       // Write aimed at advertisement

   // Identifier is pure wiring; writes never reach it
   assign id_word = {OUI_HI, MODEL, REVISION};
   assign adv_wr  = REG_REQ.wr && (REG_REQ.addr == aar_pkg::IDX_ADV);

   // Advertisement: only writable bits follow software
   // Fixed bits kept in the flops too, so the transmit word needs no mux
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         adv <= aar_pkg::ADV_RESET;
      end else if (adv_wr) begin
         // Fixed selector forced in, reserved and T4 forced out
         adv <= (REG_REQ.wdata & aar_pkg::ADV_WMASK) | aar_pkg::ADV_FIXED;
      end
   end

   // Word handed to the negotiation engine mirrors the register
   // Straight from the flops, so the engine never sees a decode glitch
   assign ADV_WORD = adv;

   // Partner capture lives in its own small block
   // Only reported bits get flops; the rest are tied low in there
   aar_partner_capture #(
      .DW   (aar_pkg::DW),
      .MASK (aar_pkg::LP_MASK),
      .RSTV (aar_pkg::LP_RESET)
   ) u_capture (
      .clk     (CLK),
      .reset_n (RESET_N),
      .clear   (LP_CLEAR),
      .valid   (LP_VALID),
      .word    (LP_WORD),
      .held    (partner)
   );

   // Read mux; unmapped indices read as zero
   // A same-cycle write lands after this sample, so reads see old data
   always_comb begin
      if (REG_REQ.addr == aar_pkg::IDX_ID_HIGH) begin
         next_rdata = id_word;
      end else if (REG_REQ.addr == aar_pkg::IDX_ADV) begin
         next_rdata = adv;
      end else if (REG_REQ.addr == aar_pkg::IDX_PARTNER) begin
         next_rdata = partner;
      end else begin
         next_rdata = aar_pkg::ZERO_WORD;
      end
   end

   // Read data registered; held between reads so software sees it stable
   // Costs one cycle of latency but keeps the answer glitch free
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RDATA <= aar_pkg::ZERO_WORD;
      end else if (REG_REQ.rd) begin
         REG_RDATA <= next_rdata;
      end
   end

   // One-cycle valid pulse per read
   // Back-to-back reads give a valid high on consecutive cycles
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         REG_RVALID <= 1'b0;
      end else begin
         REG_RVALID <= REG_REQ.rd;
      end
   end

   // Checks

   // Helper: flag set by a partner word, dropped by a clear without a new word
   logic seen_word;   // A partner word arrived since reset or clear
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         seen_word <= 1'b0;
      end else if (LP_VALID) begin
         seen_word <= 1'b1;
      end else if (LP_CLEAR) begin
         seen_word <= 1'b0;
      end
   end

   // Identifier read returns the fixed word, one cycle later
   a_id_fixed: assert property (@(posedge CLK) disable iff (!RESET_N)
      REG_REQ.rd && REG_REQ.addr == aar_pkg::IDX_ID_HIGH
      |=> REG_RVALID && REG_RDATA == {OUI_HI, MODEL, REVISION})
      else $error("identifier read returned wrong value");

   // Next-page flag follows software
   a_np_write: assert property (@(posedge CLK) disable iff (!RESET_N)
      adv_wr |=> ADV_WORD[aar_pkg::ADV_NP] == $past(REG_REQ.wdata[aar_pkg::ADV_NP]))
      else $error("next-page flag did not follow write");

   // Local fault flag follows software
   a_rf_write: assert property (@(posedge CLK) disable iff (!RESET_N)
      adv_wr |=> ADV_WORD[aar_pkg::ADV_RF] == $past(REG_REQ.wdata[aar_pkg::ADV_RF]))
      else $error("local fault flag did not follow write");

   // No write, no change: the engine must never see a stray edit
   a_abil_hold: assert property (@(posedge CLK) disable iff (!RESET_N)
      !adv_wr |=> $stable(ADV_WORD))
      else $error("advertisement changed without a write");

   // Ability flags follow software
   a_abil_write: assert property (@(posedge CLK) disable iff (!RESET_N)
      adv_wr |=> ADV_WORD[aar_pkg::ABIL_LSB +: aar_pkg::ABIL_N]
                 == $past(REG_REQ.wdata[aar_pkg::ABIL_LSB +: aar_pkg::ABIL_N]))
      else $error("ability flags did not follow write");

   // Advertisement read gives the value before any same-cycle write
   a_adv_read: assert property (@(posedge CLK) disable iff (!RESET_N)
      REG_REQ.rd && REG_REQ.addr == aar_pkg::IDX_ADV
      |=> REG_RVALID && REG_RDATA == $past(ADV_WORD))
      else $error("advertisement read returned wrong value");

   // T4 never advertised nor reported
   a_t4_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
      !ADV_WORD[aar_pkg::T4_BIT] && !partner[aar_pkg::T4_BIT])
      else $error("T4 ability bit set");

   // Selector and reserved bits of the advertisement fixed
   a_sel_fixed: assert property (@(posedge CLK) disable iff (!RESET_N)
      ADV_WORD[4:0] == 5'h01 && ADV_WORD[14] == 1'b0 && ADV_WORD[12:10] == 3'h0)
      else $error("advertised selector or reserved bits wrong");

   // Only writable bits and the selector may ever be set
   a_adv_fixed: assert property (@(posedge CLK) disable iff (!RESET_N)
      (ADV_WORD & ~(aar_pkg::ADV_WMASK | aar_pkg::ADV_FIXED)) == aar_pkg::ZERO_WORD)
      else $error("advertisement bit outside writable set");

   // Partner word captured one cycle after its strobe
   a_lp_capture: assert property (@(posedge CLK) disable iff (!RESET_N)
      LP_VALID |=> partner == ($past(LP_WORD) & aar_pkg::LP_MASK))
      else $error("partner word not captured");

   // Nothing reported before a word arrives
   a_lp_empty: assert property (@(posedge CLK) disable iff (!RESET_N)
      !seen_word |-> partner == aar_pkg::LP_RESET)
      else $error("partner bits set before any word");

   // Restart drops the partner word unless a new one lands
   a_lp_clear: assert property (@(posedge CLK) disable iff (!RESET_N)
      LP_CLEAR && !LP_VALID |=> partner == aar_pkg::LP_RESET)
      else $error("partner word survived a restart");

   // Bits the partner register never reports stay zero
   a_lp_unkept: assert property (@(posedge CLK) disable iff (!RESET_N)
      (partner & ~aar_pkg::LP_MASK) == aar_pkg::ZERO_WORD)
      else $error("unreported partner bit set");

   // Partner read returns the captured word
   a_lp_read: assert property (@(posedge CLK) disable iff (!RESET_N)
      REG_REQ.rd && REG_REQ.addr == aar_pkg::IDX_PARTNER
      |=> REG_RVALID && REG_RDATA == $past(partner))
      else $error("partner read returned wrong value");

   // Partner reserved bits read zero; back-to-back reads are legal
   a_rsvd_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
      REG_REQ.rd && REG_REQ.addr == aar_pkg::IDX_PARTNER
      |=> REG_RVALID && REG_RDATA[12:9] == 4'h0)
      else $error("partner reserved bits not zero");

   // Unmapped indices read zero
   a_unmapped_zero: assert property (@(posedge CLK) disable iff (!RESET_N)
      REG_REQ.rd && REG_REQ.addr != aar_pkg::IDX_ID_HIGH
      && REG_REQ.addr != aar_pkg::IDX_ADV && REG_REQ.addr != aar_pkg::IDX_PARTNER
      |=> REG_RVALID && REG_RDATA == aar_pkg::ZERO_WORD)
      else $error("unmapped read not zero");

   // Main scenarios
   c_adv_write: cover property (@(posedge CLK) disable iff (!RESET_N)
      adv_wr ##1 REG_REQ.rd && REG_REQ.addr == aar_pkg::IDX_ADV);

   c_lp_read: cover property (@(posedge CLK) disable iff (!RESET_N)
      LP_VALID ##[1:4] REG_REQ.rd && REG_REQ.addr == aar_pkg::IDX_PARTNER);

   c_lp_clear: cover property (@(posedge CLK) disable iff (!RESET_N)
      seen_word && LP_CLEAR && !LP_VALID);

   c_np_offer: cover property (@(posedge CLK) disable iff (!RESET_N)
      adv_wr && REG_REQ.wdata[aar_pkg::ADV_NP]);

   c_id_write: cover property (@(posedge CLK) disable iff (!RESET_N)
      REG_REQ.wr && REG_REQ.addr == aar_pkg::IDX_ID_HIGH);

endmodule

// File: verification/aar_lp_model.sv
/*
 * Stand-in for the negotiation engine feeding received partner words.
 * Assumes the bench raises send for one cycle, off the falling edge.
 */
`timescale 1ns/1ns
module aar_lp_model (
   input  wire logic        clk,      // Core clock
   input  wire logic        send,     // Deliver one word
   input  wire logic [15:0] word,     // Word to deliver
   output logic             lp_valid, // Word strobe
   output logic      [15:0] lp_word   // Word lines
);
   logic [15:0] idle = 16'h5A5A;      // Filler pattern between words

   // Filler flips every cycle so a stale sample can never pass as a word
   always @(negedge clk) begin
      idle <= ~idle;
   end

   // Strobe follows send directly, so no extra cycle of delay
   assign lp_valid = send;
   assign lp_word  = send ? word : idle;
endmodule

// File: verification/tb_autoneg_ability_registers.sv
/*
 * Self-checking bench for the ability register slice: register port
 * reads and writes plus partner word delivery.
 * Assumes one-cycle strobes and a read answer within three cycles.
 */
`timescale 1ns/1ns
module tb_autoneg_ability_registers;
   localparam logic [5:0]  OUI = 6'h2C;       // Arbitrary vendor bits
   localparam logic [5:0]  MDL = 6'h0B;       // Arbitrary model number
   localparam logic [3:0]  REV = 4'h6;        // Arbitrary revision
   localparam logic [15:0] ID  = {OUI, MDL, REV}; // Expected identifier
   logic clk = 1'b0, reset_n = 1'b0, lp_clear = 1'b0, send = 1'b0; // Drives
   logic rvalid, lp_valid;                    // Strobes seen
   logic [15:0] word = 16'h0000, rdata, adv, lp_word; // Data lines
   aar_pkg::aar_req_t req = '0;               // Register request
   int n_fail = 0, cmp_count = 0;             // Tallies

   // Clock at 125 MHz
   always #4 clk = ~clk;

   aar_regs #(.OUI_HI(OUI), .MODEL(MDL), .REVISION(REV)) uut (
      .CLK(clk), .RESET_N(reset_n), .REG_REQ(req), .REG_RDATA(rdata),
      .REG_RVALID(rvalid), .LP_VALID(lp_valid), .LP_WORD(lp_word),
      .LP_CLEAR(lp_clear), .ADV_WORD(adv));
   aar_lp_model lp (.clk(clk), .send(send), .word(word), .lp_valid(lp_valid),
      .lp_word(lp_word));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Never called twice in a row, so the strobe never bounces in one step
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.wr = 1'b0;
   endtask

   // Bounded wait for the answer pulse, then one idle cycle
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      logic seen;
      seen = 1'b0;
      req.rd = 1'b1;
      req.addr = a;
      for (int i = 0; i < 3 && !seen; i++) begin
         @(negedge clk);
         req.rd = 1'b0;
         seen = (rvalid === 1'b1);
      end
      if (!seen) begin
         n_fail++;
         $display("CHECK FAILED at %0t: no read answer", $time);
      end
      chk(rdata, exp);
      @(negedge clk);
   endtask

   // One partner word, one cycle long
   task automatic lp_send(input logic [15:0] w);
      send = 1'b1;
      word = w;
      @(negedge clk);
      send = 1'b0;
   endtask

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Watchdog: the sequence needs well under a hundred cycles
   initial begin
      #5000;
      n_fail++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      wrap_up();
   end

   // Main sequence
   initial begin
      repeat (3) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      chk(adv, 16'h01E1);
      rd(aar_pkg::IDX_ID_HIGH, ID);
      rd(aar_pkg::IDX_ADV, 16'h01E1);
      rd(aar_pkg::IDX_PARTNER, 16'h0000);
      wr(aar_pkg::IDX_ID_HIGH, ~ID);
      rd(aar_pkg::IDX_ID_HIGH, ID);
      wr(aar_pkg::IDX_ADV, 16'hFFFF);
      chk(adv, 16'hA1E1);
      rd(aar_pkg::IDX_ADV, 16'hA1E1);
      wr(aar_pkg::IDX_ADV, 16'h5E1E);
      rd(aar_pkg::IDX_ADV, 16'h0001);
      wr(aar_pkg::IDX_ADV, 16'h2040);
      rd(aar_pkg::IDX_ADV, 16'h2041);
      wr(aar_pkg::IDX_PARTNER, 16'hFFFF);
      rd(aar_pkg::IDX_PARTNER, 16'h0000);
      lp_send(16'hFFFF);
      rd(aar_pkg::IDX_PARTNER, 16'hE1FF);
      lp_send(16'hA0C1);
      rd(aar_pkg::IDX_PARTNER, 16'hA0C1);
      lp_clear = 1'b1;
      @(negedge clk);
      lp_clear = 1'b0;
      rd(aar_pkg::IDX_PARTNER, 16'h0000);
      rd(5'h1F, 16'h0000);
      // Leave a partner word behind so the reset has something to drop
      lp_send(16'h0120);
      // Second reset in mid-run must restore the defaults
      reset_n = 1'b0;
      @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      rd(aar_pkg::IDX_ADV, 16'h01E1);
      rd(aar_pkg::IDX_PARTNER, 16'h0000);
      wrap_up();
   end
endmodule
